// ===== otl_sequencer.sv
// Overcurrent protection, triggered current, arming and list sequencing with an APB slave
//
// The address map and the APB slave port are this design's own decisions.
module otl_sequencer import otl_pkg::*; #(
   parameter int TICK_CYCLES = DWELL_TICK_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic cc_status_i,
   input wire logic trigger_i,
   output logic output_enable_o,
   output logic [LVL_W-1:0] current_level_o,
   output logic [LVL_W-1:0] voltage_level_o,
   output logic readout_enable_o,
   output logic annunciator_cc_o,
   output logic annunciator_oc_o
);
   // Clamp a list length into 1..20
   function automatic logic [IDX_W-1:0] clamp_len(input logic [7:0] v);
      if (v[IDX_W-1:0] == '0 && v[7:IDX_W] == '0) return PTS_MIN;
      if (v > {3'h0, PTS_MAX}) return PTS_MAX;
      return v[IDX_W-1:0];
   endfunction : clamp_len
   // A single point list repeats its one value
   function automatic logic [IDX_W-1:0] pick(input logic [IDX_W-1:0] len,
                                             input logic [IDX_W-1:0] idx);
      return (len == PTS_MIN) ? '0 : idx;
   endfunction : pick

   otl_ctrl_type ctrl_ff;
   otl_seq_type state_ff;
   logic [DATA_W-1:0] repeat_ff, prdata_ff;
   logic [LVL_W-1:0] imm_immediate_current_setpoint_ff, imm_volt_ff, pend_val_ff;
   logic [LVL_W-1:0] volt_tab [PTS_MAX];
   logic [LVL_W-1:0] immediate_current_setpoint_tab [PTS_MAX];
   logic [DWELL_W-1:0] dwell_tab [PTS_MAX];
   logic [IDX_W-1:0] len_v_ff, len_c_ff, len_d_ff, idx_ff;
   logic [15:0] pass_ff;
   logic [DWELL_W-1:0] dwell_left_ff;
   logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_ff;
   logic pend_valid_ff, armed_ff, oc_flag_ff, list_err_ff;
   logic cc_meta_ff, cc_sync_ff, trg_meta_ff, trg_sync_ff, trg_prev_ff;

   // Bus decode
   logic setup, wr_en, mapped, tab_hit;
   logic [3:0] page;
   logic [IDX_W-1:0] tab_idx;
   assign setup = psel_i & ~penable_i;
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign page = paddr_i[11:8];
   assign tab_idx = paddr_i[6:2];
   assign tab_hit = (page == PAGE_VOLT || page == PAGE_IMMEDIATE_CURRENT_SETPOINT || page == PAGE_DWELL)
                    && paddr_i[7] == 1'b0 && paddr_i[1:0] == 2'h0 && tab_idx < PTS_MAX;
   always_comb begin
      unique case (paddr_i)
         ADDR_CTRL, ADDR_CMD, ADDR_IMMEDIATE_CURRENT_SETPOINT_IMM, ADDR_PENDING_CURRENT_SETPOINT, ADDR_VOLT_IMM,
         ADDR_REPEAT, ADDR_LIST_LEN, ADDR_STATUS: mapped = 1'b1;
         default: mapped = tab_hit;
      endcase
   end
   // Answer in the access cycle; unmapped addresses report an error
   assign pready_o = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & ~mapped;

   // Write strobes
   logic wr_ctrl, wr_cmd, wr_list, list_sel, abort, rst_cmd, pclear, arm_cmd;
   otl_ctrl_type wctrl;
   assign wctrl = otl_ctrl_type'(pwdata_i[6:0]);
   assign wr_ctrl = wr_en && paddr_i == ADDR_CTRL;
   assign wr_cmd = wr_en && paddr_i == ADDR_CMD;
   assign wr_list = wr_en && (tab_hit || paddr_i == ADDR_REPEAT || paddr_i == ADDR_LIST_LEN);
   assign list_sel = wr_ctrl && (wctrl.immediate_current_setpoint_list || wctrl.volt_list);
   assign rst_cmd = wr_cmd & pwdata_i[CMD_RESET];
   assign pclear = wr_cmd & pwdata_i[CMD_PCLEAR];
   assign arm_cmd = wr_cmd & pwdata_i[CMD_ARM];
   assign abort = (wr_cmd & pwdata_i[CMD_ABORT]) | rst_cmd | wr_list | list_sel;

   // Pin synchronisers and trigger edge
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cc_meta_ff <= 1'b0;
         cc_sync_ff <= 1'b0;
         trg_meta_ff <= 1'b0;
         trg_sync_ff <= 1'b0;
         trg_prev_ff <= 1'b0;
      end else begin
         cc_meta_ff <= cc_status_i;
         cc_sync_ff <= cc_meta_ff;
         trg_meta_ff <= trigger_i;
         trg_sync_ff <= trg_meta_ff;
         trg_prev_ff <= trg_sync_ff;
      end
   end

   // Trigger acceptance
   logic trig_evt, armed_eff, trig_go, list_on, mismatch;
   logic [IDX_W-1:0] eff_len, m1;
   assign trig_evt = (trg_sync_ff & ~trg_prev_ff) | (wr_cmd & pwdata_i[CMD_TRIG]);
   assign armed_eff = armed_ff | ctrl_ff.continuous_arm;
   assign trig_go = trig_evt & armed_eff & (state_ff != SEQ_DWELL) & ~abort;
   assign list_on = ctrl_ff.immediate_current_setpoint_list | ctrl_ff.volt_list;
   // Longest list sets the length; single point lists stretch to it
   assign m1 = (len_v_ff > len_c_ff) ? len_v_ff : len_c_ff;
   assign eff_len = (m1 > len_d_ff) ? m1 : len_d_ff;
   assign mismatch = (len_v_ff != PTS_MIN && len_v_ff != eff_len) ||
                     (len_c_ff != PTS_MIN && len_c_ff != eff_len) ||
                     (len_d_ff != PTS_MIN && len_d_ff != eff_len);

   // Dwell timing
   logic tick, expire, at_last, finished, unbounded;
   assign tick = (tick_cnt_ff == ($bits(tick_cnt_ff))'(TICK_CYCLES - 1));
   assign expire = (state_ff == SEQ_DWELL) && tick && dwell_left_ff == DWELL_MIN;
   assign unbounded = repeat_ff > REPEAT_UNBOUNDED_ABOVE;
   assign at_last = idx_ff == eff_len - PTS_MIN;
   assign finished = at_last && !unbounded && {16'h0, pass_ff + 16'h1} >= repeat_ff;

   // Point to apply next: start, trigger from wait, or auto advance
   logic start, step, apply;
   logic [IDX_W-1:0] nxt_idx;
   assign start = trig_go && list_on && state_ff == SEQ_IDLE && !mismatch;
   assign step = (trig_go && state_ff == SEQ_WAIT) ||
                 (expire && !finished && !ctrl_ff.step_once && !abort);
   assign apply = start | step;
   assign nxt_idx = start ? '0 : (at_last ? '0 : idx_ff + PTS_MIN);

   // Sequencer state, point index and pass count
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= SEQ_IDLE;
         idx_ff <= '0;
         pass_ff <= '0;
      end else if (abort) begin
         state_ff <= SEQ_IDLE;
      end else if (apply) begin
         state_ff <= SEQ_DWELL;
         idx_ff <= nxt_idx;
         if (start) begin
            pass_ff <= '0;
         end else if (at_last) begin
            pass_ff <= pass_ff + 16'h1;
         end
      end else if (expire) begin
         state_ff <= finished ? SEQ_IDLE : SEQ_WAIT;
      end
   end

   // Dwell countdown in 10 ms ticks, restarted at each point
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         tick_cnt_ff <= '0;
         dwell_left_ff <= DWELL_MIN;
      end else if (apply) begin
         tick_cnt_ff <= '0;
         dwell_left_ff <= dwell_tab[pick(len_d_ff, nxt_idx)];
      end else if (tick) begin
         tick_cnt_ff <= '0;
         if (dwell_left_ff != DWELL_MIN) begin
            dwell_left_ff <= dwell_left_ff - DWELL_MIN;
         end
      end else begin
         tick_cnt_ff <= tick_cnt_ff + ($bits(tick_cnt_ff))'(1);
      end
   end

   // Arming: one-shot arm is used up by one trigger action
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         armed_ff <= 1'b0;
      end else if (abort) begin
         armed_ff <= 1'b0;
      end else if (arm_cmd) begin
         armed_ff <= 1'b1;
      end else if (trig_go) begin
         armed_ff <= 1'b0;
      end
   end

   // Control register and reset command defaults
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_ff <= CTRL_RESET;
      end else if (rst_cmd) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff <= wctrl;
      end
   end

   // Repeat count and list lengths
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         repeat_ff <= REPEAT_RESET;
         len_v_ff <= PTS_MIN;
         len_c_ff <= PTS_MIN;
         len_d_ff <= PTS_MIN;
      end else if (rst_cmd) begin
         repeat_ff <= REPEAT_RESET;
      end else if (wr_en && paddr_i == ADDR_REPEAT) begin
         repeat_ff <= (pwdata_i == '0) ? REPEAT_RESET : pwdata_i;
      end else if (wr_en && paddr_i == ADDR_LIST_LEN) begin
         len_v_ff <= clamp_len(pwdata_i[LEN_VOLT_LSB +: 8]);
         len_c_ff <= clamp_len(pwdata_i[LEN_IMMEDIATE_CURRENT_SETPOINT_LSB +: 8]);
         len_d_ff <= clamp_len(pwdata_i[LEN_DWELL_LSB +: 8]);
      end
   end

   // Point tables
   always_ff @(posedge clk_sys_i) begin
      if (wr_en && tab_hit) begin
         if (page == PAGE_VOLT) begin
            volt_tab[tab_idx] <= pwdata_i[LVL_W-1:0];
         end
         if (page == PAGE_IMMEDIATE_CURRENT_SETPOINT) begin
            immediate_current_setpoint_tab[tab_idx] <= pwdata_i[LVL_W-1:0];
         end
         if (page == PAGE_DWELL) begin
            if (pwdata_i[DATA_W-1:DWELL_W] != '0 || pwdata_i[DWELL_W-1:0] > DWELL_MAX) begin
               dwell_tab[tab_idx] <= DWELL_MAX;
            end else if (pwdata_i[DWELL_W-1:0] < DWELL_MIN) begin
               dwell_tab[tab_idx] <= DWELL_MIN;
            end else begin
               dwell_tab[tab_idx] <= pwdata_i[DWELL_W-1:0];
            end
         end
      end
   end

   // Pending triggered current
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         pend_valid_ff <= 1'b0;
         pend_val_ff <= '0;
      end else if (abort || trig_go) begin
         pend_valid_ff <= 1'b0;
      end else if (wr_en && paddr_i == ADDR_PENDING_CURRENT_SETPOINT && armed_eff) begin
         pend_valid_ff <= 1'b1;
         pend_val_ff <= pwdata_i[LVL_W-1:0];
      end
   end

   // Output current: direct write, list point, trigger transfer
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         imm_immediate_current_setpoint_ff <= '0;
      end else if (wr_en && paddr_i == ADDR_IMMEDIATE_CURRENT_SETPOINT_IMM) begin
         imm_immediate_current_setpoint_ff <= pwdata_i[LVL_W-1:0];
      end else if (apply && ctrl_ff.immediate_current_setpoint_list) begin
         imm_immediate_current_setpoint_ff <= immediate_current_setpoint_tab[pick(len_c_ff, nxt_idx)];
      end else if (trig_go && pend_valid_ff) begin
         imm_immediate_current_setpoint_ff <= pend_val_ff;
      end
   end

   // Output voltage: direct write or list point
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         imm_volt_ff <= '0;
      end else if (wr_en && paddr_i == ADDR_VOLT_IMM) begin
         imm_volt_ff <= pwdata_i[LVL_W-1:0];
      end else if (apply && ctrl_ff.volt_list) begin
         imm_volt_ff <= volt_tab[pick(len_v_ff, nxt_idx)];
      end
   end

   // Overcurrent latch and list error; a new event wins over a clear
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         oc_flag_ff <= 1'b0;
         list_err_ff <= 1'b0;
      end else begin
         if (ctrl_ff.overcurrent_protect_enable && cc_sync_ff) begin
            oc_flag_ff <= 1'b1;
         end else if (pclear) begin
            oc_flag_ff <= 1'b0;
         end
         if (trig_go && list_on && state_ff == SEQ_IDLE && mismatch) begin
            list_err_ff <= 1'b1;
         end else if (abort) begin
            list_err_ff <= 1'b0;
         end
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         prdata_ff <= '0;
      end else if (setup && !pwrite_i) begin
         prdata_ff <= '0;
         unique case (paddr_i)
            ADDR_CTRL: prdata_ff[6:0] <= ctrl_ff;
            ADDR_IMMEDIATE_CURRENT_SETPOINT_IMM: prdata_ff[LVL_W-1:0] <= imm_immediate_current_setpoint_ff;
            ADDR_PENDING_CURRENT_SETPOINT: prdata_ff[LVL_W-1:0] <= pend_valid_ff ? pend_val_ff : imm_immediate_current_setpoint_ff;
            ADDR_VOLT_IMM: prdata_ff[LVL_W-1:0] <= imm_volt_ff;
            ADDR_REPEAT: prdata_ff <= repeat_ff;
            ADDR_LIST_LEN: prdata_ff <= {11'h0, len_d_ff, 3'h0, len_c_ff, 3'h0, len_v_ff};
            ADDR_STATUS: prdata_ff <= {21'h0, idx_ff, pend_valid_ff, list_err_ff,
                                       state_ff == SEQ_DWELL, state_ff != SEQ_IDLE,
                                       armed_eff, oc_flag_ff};
            default: prdata_ff <= '0;
         endcase
      end
   end
   assign prdata_o = prdata_ff;

   // Pin outputs; annunciators do not depend on the readout switch
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         output_enable_o <= 1'b0;
         readout_enable_o <= 1'b1;
         annunciator_cc_o <= 1'b0;
         annunciator_oc_o <= 1'b0;
      end else begin
         output_enable_o <= ctrl_ff.out_enable & ~oc_flag_ff;
         readout_enable_o <= ctrl_ff.readout_enable;
         annunciator_cc_o <= cc_sync_ff;
         annunciator_oc_o <= oc_flag_ff;
      end
   end
   assign current_level_o = imm_immediate_current_setpoint_ff;
   assign voltage_level_o = imm_volt_ff;

   // Checks
   sequence s_list_start;
      state_ff == SEQ_IDLE && trig_go && list_on && !mismatch;
   endsequence
   sequence s_in_point0;
      state_ff == SEQ_DWELL && idx_ff == '0;
   endsequence
   AST_OC_TRIP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ctrl_ff.overcurrent_protect_enable && cc_sync_ff |=> oc_flag_ff ##1 !output_enable_o)
      else $error("overcurrent did not disable output");
   AST_OC_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      oc_flag_ff && !pclear |=> oc_flag_ff)
      else $error("overcurrent flag cleared without clear command");
   AST_TRIG_COPY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      trig_go && pend_valid_ff && !wr_en && !(apply && ctrl_ff.immediate_current_setpoint_list)
      |=> imm_immediate_current_setpoint_ff == $past(pend_val_ff))
      else $error("pending current not applied on trigger");
   AST_PEND_KEEP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      pend_valid_ff && !trig_go && !abort && !(wr_en && paddr_i == ADDR_PENDING_CURRENT_SETPOINT)
      |=> pend_valid_ff && $stable(pend_val_ff))
      else $error("pending current lost");
   AST_QUERY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      setup && !pwrite_i && paddr_i == ADDR_PENDING_CURRENT_SETPOINT && !pend_valid_ff
      |=> prdata_o[LVL_W-1:0] == $past(imm_immediate_current_setpoint_ff))
      else $error("pending query did not return immediate level");
   AST_UNARMED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      state_ff == SEQ_IDLE && !armed_eff |=> state_ff == SEQ_IDLE)
      else $error("sequence started while not armed");
   AST_ONE_SHOT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      trig_go && !ctrl_ff.continuous_arm && !arm_cmd |=> !armed_ff)
      else $error("one-shot arm not consumed");
   AST_DWELL_IGNORE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      state_ff == SEQ_DWELL && trig_evt && !abort && !expire |=> $stable(idx_ff))
      else $error("trigger acted during dwell");
   AST_LIST_START: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_list_start |=> s_in_point0)
      else $error("list did not start at first point");
   AST_LIST_ABORT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_list |=> state_ff == SEQ_IDLE && !pend_valid_ff)
      else $error("list write did not abort");
   AST_FIXED_IMMEDIATE_CURRENT_SETPOINT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      apply && !ctrl_ff.immediate_current_setpoint_list && !wr_en && !pend_valid_ff |=> $stable(imm_immediate_current_setpoint_ff))
      else $error("list changed current in fixed mode");
   AST_MISMATCH: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      trig_go && list_on && state_ff == SEQ_IDLE && mismatch |=> list_err_ff && state_ff == SEQ_IDLE)
      else $error("length mismatch not reported");
endmodule : otl_sequencer

// ===== otl_pkg.sv
// Constants, register map and types of the output trigger and list sequencer
package otl_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int LVL_W = 16;
   localparam int IDX_W = 5;
   localparam int DWELL_W = 13;
   localparam logic [IDX_W-1:0] PTS_MAX = 5'h14;
   localparam logic [IDX_W-1:0] PTS_MIN = 5'h01;
   // Register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_IMMEDIATE_CURRENT_SETPOINT_IMM = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_PENDING_CURRENT_SETPOINT = 12'h00C;
   localparam logic [ADDR_W-1:0] ADDR_VOLT_IMM = 12'h010;
   localparam logic [ADDR_W-1:0] ADDR_REPEAT = 12'h014;
   localparam logic [ADDR_W-1:0] ADDR_LIST_LEN = 12'h018;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h01C;
   // Point tables: page in address bits 11:8, point index in bits 6:2
   localparam logic [3:0] PAGE_VOLT = 4'h1;
   localparam logic [3:0] PAGE_IMMEDIATE_CURRENT_SETPOINT = 4'h2;
   localparam logic [3:0] PAGE_DWELL = 4'h3;
   // Command register bits (write one to act)
   localparam int CMD_ARM = 0;
   localparam int CMD_ABORT = 1;
   localparam int CMD_TRIG = 2;
   localparam int CMD_PCLEAR = 3;
   localparam int CMD_RESET = 4;
   // List length fields
   localparam int LEN_VOLT_LSB = 0;
   localparam int LEN_IMMEDIATE_CURRENT_SETPOINT_LSB = 8;
   localparam int LEN_DWELL_LSB = 16;
   // Repeat count
   localparam logic [DATA_W-1:0] REPEAT_UNBOUNDED_ABOVE = 32'h0000FFFE;
   localparam logic [DATA_W-1:0] REPEAT_RESET = 32'h00000001;
   // Dwell in 10 ms ticks: 0.01 s to 65 s
   localparam logic [DWELL_W-1:0] DWELL_MIN = 13'h0001;
   localparam logic [DWELL_W-1:0] DWELL_MAX = 13'h1964;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DWELL_TICK_NS = 10000000;
   localparam int DWELL_TICK_CYCLES = (DWELL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Control register layout, bit 6 down to bit 0
   typedef struct packed {
      logic volt_list;
      logic immediate_current_setpoint_list;
      logic step_once;
      logic out_enable;
      logic readout_enable;
      logic continuous_arm;
      logic overcurrent_protect_enable;
   } otl_ctrl_type;
   localparam otl_ctrl_type CTRL_RESET = 7'h04;
   // Sequencer states
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_DWELL, SEQ_WAIT} otl_seq_type;
endpackage : otl_pkg

// ===== otl_apb_master.sv
// Bus controller model: APB master issuing register transfers
module otl_apb_master import otl_pkg::*; (
   input wire logic clk_sys_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [ADDR_W-1:0] paddr_o,
   output logic [DATA_W-1:0] pwdata_o,
   input wire logic [DATA_W-1:0] prdata_i,
   input wire logic pready_i,
   input wire logic pslverr_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = '0;
      pwdata_o = '0;
   end
   // Setup, access held until pready, release, then one idle edge
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] q, output logic err);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_sys_i);
      penable_o <= 1'b1;
      @(posedge clk_sys_i);
      while (pready_i !== 1'b1) @(posedge clk_sys_i);
      q = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d; // Released data must not look valid
      @(posedge clk_sys_i);
   endtask : xfer
endmodule : otl_apb_master

// ===== otl_sequencer_tb.sv
// Self-checking bench for the output trigger and list sequencer
module otl_sequencer_tb import otl_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 4;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, e;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, q;
   logic cc = 1'b0;
   logic trig = 1'b0;
   logic oen, rden, ann_cc, ann_oc;
   logic [LVL_W-1:0] cur, volt, last_volt = '0;
   logic [LVL_W-1:0] vq[$];
   int tq[$];
   int cyc = 0;
   int miscompares = 0;
   int checked = 0;
   // 100 MHz clock
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   otl_apb_master i_bus (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
      .pready_i(pready), .pslverr_i(pslverr));
   otl_sequencer #(.TICK_CYCLES(TC)) i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .cc_status_i(cc), .trigger_i(trig), .output_enable_o(oen), .current_level_o(cur),
      .voltage_level_o(volt), .readout_enable_o(rden), .annunciator_cc_o(ann_cc),
      .annunciator_oc_o(ann_oc));
   // Log each voltage setpoint change with its cycle number
   always @(posedge clk_sys_i) begin
      cyc++;
      if (volt !== last_volt) begin
         vq.push_back(volt);
         tq.push_back(cyc);
         last_volt = volt;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      i_bus.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, exp);
      i_bus.xfer(1'b0, a, '0, q, e);
      check(q & m, exp);
   endtask : rd_chk
   task automatic cmd(input int b);
      wr(ADDR_CMD, 32'h00000001 << b);
   endtask : cmd
   task automatic give_verdict();
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      tick(16);
      reset_i <= 1'b0;
      tick(1);
      rd_chk(ADDR_CTRL, 32'h0000007F, 32'h00000004);
      rd_chk(ADDR_REPEAT, 32'hFFFFFFFF, REPEAT_RESET);
      check({31'h0, rden}, 32'h1);
      i_bus.xfer(1'b0, 12'h0F0, '0, q, e);
      check({31'h0, e}, 32'h1);
      // Unarmed: triggered level refused, triggers ignored
      wr(ADDR_IMMEDIATE_CURRENT_SETPOINT_IMM, 32'h10);
      wr(ADDR_PENDING_CURRENT_SETPOINT, 32'h55);
      rd_chk(ADDR_PENDING_CURRENT_SETPOINT, 32'hFFFF, 32'h10);
      cmd(CMD_TRIG);
      tick(3);
      check({16'h0, cur}, 32'h10);
      // Armed: pending level survives immediate writes, pin edge applies it
      cmd(CMD_ARM);
      wr(ADDR_PENDING_CURRENT_SETPOINT, 32'h55);
      wr(ADDR_IMMEDIATE_CURRENT_SETPOINT_IMM, 32'h20);
      rd_chk(ADDR_PENDING_CURRENT_SETPOINT, 32'hFFFF, 32'h55);
      check({16'h0, cur}, 32'h20);
      trig <= 1'b1;
      tick(4);
      trig <= 1'b0;
      tick(4);
      check({16'h0, cur}, 32'h55);
      rd_chk(ADDR_STATUS, 32'h22, 32'h0);
      // Abort drops a pending level
      cmd(CMD_ARM);
      wr(ADDR_PENDING_CURRENT_SETPOINT, 32'h66);
      cmd(CMD_ABORT);
      cmd(CMD_ARM);
      cmd(CMD_TRIG);
      tick(3);
      check({16'h0, cur}, 32'h55);
      // Continuous arming needs no arm command between triggers
      wr(ADDR_CTRL, 32'h06);
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_PENDING_CURRENT_SETPOINT, 32'h77 + i);
         cmd(CMD_TRIG);
         tick(3);
         check({16'h0, cur}, 32'h77 + i);
      end
      // Overcurrent latch, readout switch, protection clear
      wr(ADDR_CTRL, 32'h0D);
      tick(1);
      check({31'h0, oen}, 32'h1);
      cc <= 1'b1;
      tick(8);
      check({30'h0, oen, ann_cc}, 32'h1);
      rd_chk(ADDR_STATUS, 32'h1, 32'h1);
      cc <= 1'b0;
      tick(8);
      wr(ADDR_CTRL, 32'h09);
      tick(1);
      check({29'h0, oen, rden, ann_oc}, 32'h1);
      cmd(CMD_PCLEAR);
      tick(3);
      check({31'h0, oen}, 32'h1);
      // Auto list: two voltage points, one dwell point, two passes
      wr(ADDR_LIST_LEN, 32'h00010202);
      wr({PAGE_VOLT, 8'h00}, 32'h11);
      wr({PAGE_VOLT, 8'h04}, 32'h22);
      wr({PAGE_DWELL, 8'h00}, 32'h2);
      wr(ADDR_REPEAT, 32'h2);
      wr(ADDR_CTRL, 32'h42);
      vq.delete();
      tq.delete();
      cmd(CMD_TRIG);
      tick(60);
      check(32'(vq.size()), 32'h4);
      for (int i = 0; i < 4; i++) begin
         check({16'h0, vq[i]}, (i % 2) ? 32'h22 : 32'h11);
         if (i > 0) check(32'(tq[i] - tq[i-1]), 32'(2 * TC));
      end
      rd_chk(ADDR_STATUS, 32'h4, 32'h0);
      check({16'h0, cur}, 32'h78);
      // Single step: one point per trigger, triggers in dwell ignored
      wr(ADDR_CTRL, 32'h52);
      vq.delete();
      tq.delete();
      cmd(CMD_TRIG);
      cmd(CMD_TRIG);
      tick(30);
      check(32'(vq.size()), 32'h1);
      cmd(CMD_TRIG);
      tick(30);
      check({16'h0, vq[$]}, 32'h22);
      // Repeat count above the limit keeps the list running
      wr(ADDR_REPEAT, 32'h0000FFFF);
      wr(ADDR_CTRL, 32'h42);
      cmd(CMD_TRIG);
      tick(60);
      rd_chk(ADDR_STATUS, 32'h4, 32'h4);
      // Length mismatch flags an error at list start
      wr(ADDR_LIST_LEN, 32'h00010302);
      cmd(CMD_TRIG);
      tick(3);
      rd_chk(ADDR_STATUS, 32'h10, 32'h10);
      // Current list mode drives the output current from its point
      wr({PAGE_IMMEDIATE_CURRENT_SETPOINT, 8'h00}, 32'h33);
      wr(ADDR_LIST_LEN, 32'h00010101);
      wr(ADDR_CTRL, 32'h22);
      cmd(CMD_TRIG);
      tick(3);
      check({16'h0, cur}, 32'h33);
      // Reset command restores the defaults
      cmd(CMD_RESET);
      rd_chk(ADDR_CTRL, 32'h0000007F, 32'h00000004);
      rd_chk(ADDR_REPEAT, 32'hFFFFFFFF, REPEAT_RESET);
      give_verdict();
   end
   // Watchdog for a hung run
   initial begin
      tick(4000);
      miscompares++;
      give_verdict();
   end
endmodule : otl_sequencer_tb
